// file: rtl/amg_ea_gen.sv
// Behaviour
// - Inherent instructions are one opcode byte, no operand bytes.
// - Immediate takes the next byte as operand; two-byte instruction.
// - Short direct uses one address byte, reach 00 to FF.
// - Long direct uses a two-byte address over the 64 Kbyte space.
// - Indexed address is unsigned sum of selected index and offset.
// - No-offset indexed uses the index value alone, 00 to FF.
// - No-offset indexed adds no byte after the opcode with either index.
// - Short indexed: one offset byte, sum spans 00 to 1FE, no wrap.
// - Long indexed: two-byte offset plus index over 64 Kbyte.
// - Indirect uses the byte after opcode as pointer, reads address there.
// - Short indirect reads a one-byte pointer, address within 00 to FF.
// - Long indirect reads a two-byte pointer word from a byte address.
// - Indirect indexed adds index to the pointer fetched from memory.
// - Short indirect indexed: byte pointer plus index, 00 to 1FE.
// - Relative adds signed 8-bit displacement to next-instruction PC.
// - Short variants reach page zero and are shorter than long ones.
// - Read-modify-write instructions use short addressing forms only.
// - Lead code 90 swaps in the second index register.
// - Lead code 92 turns direct and offset indexed forms into indirect ones; no-offset indexed stays direct.
module amg_ea_gen (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [7:0] fetch_byte,
    input wire logic fetch_valid,
    input wire logic [7:0] idx_first,
    input wire logic [7:0] idx_second,
    input wire logic [15:0] pc_next,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic fetch_req,
    output logic done,
    output amg_pkg::amg_result_t result,
    output amg_pkg::amg_mode_t mode_out,
    output logic rmw_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        AMG_IDLE,
        AMG_OPC,
        AMG_B1,
        AMG_B2,
        AMG_PTR_HI,
        AMG_PTR_LO,
        AMG_DONE
    } amg_state_t;

    amg_state_t state;
    amg_pkg::amg_instr_t instr;
    amg_pkg::amg_mode_t mode;
    logic rmw;
    logic [7:0] ptr_hi;
    logic [1:0] needed;
    logic [15:0] next_ea;
    logic [7:0] idx;
    logic indirect;
    logic take_opc;
    logic take_b1;
    logic take_b2;
    logic ptr_ok;
    logic ptr_word;
    logic ptr_lo_ok;

    amg_mode_decode u_dec (
        .instr(instr),
        .mode(mode),
        .rmw(rmw)
    );

    // ------------------------------------------------------------
    // Bytes following the opcode
    // ------------------------------------------------------------
    function automatic logic [1:0] amg_follow(input amg_pkg::amg_mode_t m);
        unique case (m)
            amg_pkg::AMG_INHERENT: amg_follow = 2'h0;
            amg_pkg::AMG_IMMEDIATE: amg_follow = 2'h1;
            amg_pkg::AMG_DIRECT_SHORT: amg_follow = 2'h1;
            amg_pkg::AMG_DIRECT_LONG: amg_follow = 2'h2;
            amg_pkg::AMG_INDEXED_NONE: amg_follow = 2'h0;
            amg_pkg::AMG_INDEXED_SHORT: amg_follow = 2'h1;
            amg_pkg::AMG_INDEXED_LONG: amg_follow = 2'h2;
            amg_pkg::AMG_RELATIVE: amg_follow = 2'h1;
            amg_pkg::AMG_BIT_DIRECT: amg_follow = 2'h1;
            amg_pkg::AMG_BIT_RELATIVE: amg_follow = 2'h2;
        endcase
    endfunction : amg_follow

    function automatic logic amg_short(input amg_pkg::amg_mode_t m);
        amg_short = (m != amg_pkg::AMG_DIRECT_LONG) && (m != amg_pkg::AMG_INDEXED_LONG);
    endfunction : amg_short

    function automatic logic amg_is_long(input amg_pkg::amg_mode_t m);
        amg_is_long = (m == amg_pkg::AMG_DIRECT_LONG) || (m == amg_pkg::AMG_INDEXED_LONG);
    endfunction : amg_is_long

    function automatic logic amg_is_lead(input logic [7:0] b);
        amg_is_lead = (b == amg_pkg::ALT_PTR_LEAD_CODE) || (b == amg_pkg::DEREF_LEAD_CODE)
            || (b == amg_pkg::ALT_DEREF_LEAD_CODE);
    endfunction : amg_is_lead

    function automatic logic [1:0] amg_len(input amg_pkg::amg_mode_t m, input logic ind);
        // Indirect: only the pointer address, plus a bit branch offset
        if (ind) begin
            amg_len = (m == amg_pkg::AMG_BIT_RELATIVE) ? 2'h2 : 2'h1;
        end else begin
            amg_len = amg_follow(m);
        end
    endfunction : amg_len

    // Long indirect only where the form was long before the lead code
    assign indirect = instr.deref && (mode != amg_pkg::AMG_INHERENT)
        && (mode != amg_pkg::AMG_IMMEDIATE) && (mode != amg_pkg::AMG_INDEXED_NONE);
    assign idx = instr.alt_index ? idx_second : idx_first;
    assign needed = amg_follow(mode);
    assign take_opc = (state == AMG_OPC) && fetch_valid;
    assign take_b1 = (state == AMG_B1) && (needed != 2'h0) && fetch_valid;
    assign take_b2 = (state == AMG_B2) && fetch_valid;
    assign ptr_ok = (state == AMG_PTR_HI) && mem_rvalid;
    assign ptr_word = ptr_ok && amg_is_long(mode);
    assign ptr_lo_ok = (state == AMG_PTR_LO) && mem_rvalid;

    // ------------------------------------------------------------
    // Effective address
    // ------------------------------------------------------------
    always_comb begin
        next_ea = amg_pkg::RESET_ADDR;
        unique case (mode)
            amg_pkg::AMG_DIRECT_SHORT, amg_pkg::AMG_BIT_DIRECT, amg_pkg::AMG_BIT_RELATIVE: begin
                next_ea = {8'h00, instr.byte1};
            end
            amg_pkg::AMG_DIRECT_LONG: begin
                next_ea = {instr.byte1, instr.byte2};
            end
            amg_pkg::AMG_INDEXED_NONE: begin
                next_ea = {8'h00, idx};
            end
            amg_pkg::AMG_INDEXED_SHORT: begin
                next_ea = {8'h00, instr.byte1} + {8'h00, idx};
            end
            amg_pkg::AMG_INDEXED_LONG: begin
                next_ea = {instr.byte1, instr.byte2} + {8'h00, idx};
            end
            amg_pkg::AMG_RELATIVE: begin
                next_ea = pc_next + {{8{instr.byte1[7]}}, instr.byte1};
            end
            default: next_ea = amg_pkg::RESET_ADDR;
        endcase
    end

    // ------------------------------------------------------------
    // State sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= AMG_IDLE;
        end else if (clk_en) begin
            unique case (state)
                AMG_IDLE: begin
                    if (start) begin
                        state <= AMG_OPC;
                    end
                end
                AMG_OPC: begin
                    if (take_opc && !amg_is_lead(fetch_byte)) begin
                        state <= AMG_B1;
                    end
                end
                AMG_B1: begin
                    if (needed == 2'h0) begin
                        state <= AMG_DONE;
                    end else if (take_b1) begin
                        if (indirect) begin
                            state <= AMG_PTR_HI;
                        end else if (needed == 2'h2) begin
                            state <= AMG_B2;
                        end else begin
                            state <= AMG_DONE;
                        end
                    end
                end
                AMG_B2: begin
                    if (take_b2) begin
                        state <= AMG_DONE;
                    end
                end
                AMG_PTR_HI: begin
                    if (ptr_word) begin
                        state <= AMG_PTR_LO;
                    end else if (ptr_ok) begin
                        state <= (mode == amg_pkg::AMG_BIT_RELATIVE) ? AMG_B2 : AMG_DONE;
                    end
                end
                AMG_PTR_LO: begin
                    if (ptr_lo_ok) begin
                        state <= AMG_DONE;
                    end
                end
                AMG_DONE: state <= AMG_IDLE;
                default: state <= AMG_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Instruction capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            instr <= '0;
        end else if (clk_en) begin
            if ((state == AMG_IDLE) && start) begin
                instr <= '0;
            end else if (take_opc) begin
                if (fetch_byte == amg_pkg::ALT_PTR_LEAD_CODE) begin
                    instr.alt_index <= 1'b1;
                end else if (fetch_byte == amg_pkg::DEREF_LEAD_CODE) begin
                    instr.deref <= 1'b1;
                end else if (fetch_byte == amg_pkg::ALT_DEREF_LEAD_CODE) begin
                    instr.deref <= 1'b1;
                    instr.alt_index <= 1'b1;
                end else begin
                    instr.opcode <= fetch_byte;
                end
            end else if (take_b1) begin
                instr.byte1 <= fetch_byte;
            end else if (take_b2) begin
                instr.byte2 <= fetch_byte;
            end else if (ptr_ok && !ptr_word) begin
                // Byte pointer substitutes for the short address/offset
                instr.byte1 <= mem_rdata;
            end else if (ptr_lo_ok) begin
                instr.byte1 <= ptr_hi;
                instr.byte2 <= mem_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Pointer reads and address port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr_hi <= amg_pkg::RESET_BYTE;
        end else if (clk_en && ptr_word) begin
            ptr_hi <= mem_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= amg_pkg::RESET_ADDR;
            mem_rd <= 1'b0;
        end else if (clk_en) begin
            mem_rd <= 1'b0;
            if (take_b1 && indirect) begin
                mem_addr <= {8'h00, fetch_byte};
                mem_rd <= 1'b1;
            end else if (ptr_word) begin
                mem_addr <= mem_addr + 16'h0001;
                mem_rd <= 1'b1;
            end else if (((state == AMG_PTR_HI) || (state == AMG_PTR_LO)) && !mem_rvalid) begin
                mem_rd <= 1'b1;
            end else if (state == AMG_DONE) begin
                mem_addr <= next_ea;
            end
        end
    end

    // ------------------------------------------------------------
    // Code byte requests
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fetch_req <= 1'b0;
        end else if (clk_en) begin
            if ((state == AMG_IDLE) && start) begin
                fetch_req <= 1'b1;
            end else if ((state == AMG_B1) && (needed == 2'h0)) begin
                fetch_req <= 1'b0;
            end else if (take_b1 && (indirect || (needed == 2'h1))) begin
                fetch_req <= 1'b0;
            end else if (take_b2) begin
                fetch_req <= 1'b0;
            end else if (ptr_ok && !ptr_word && (mode == amg_pkg::AMG_BIT_RELATIVE)) begin
                fetch_req <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Result
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
            result <= '0;
            mode_out <= amg_pkg::AMG_INHERENT;
            rmw_out <= 1'b0;
        end else if (clk_en) begin
            done <= (state == AMG_DONE);
            if (state == AMG_DONE) begin
                result.ea <= next_ea;
                result.operand <= instr.byte1;
                result.is_operand <= (mode == amg_pkg::AMG_IMMEDIATE);
                result.len <= amg_len(mode, indirect);
                result.short_form <= amg_short(mode);
                mode_out <= mode;
                rmw_out <= rmw;
            end
        end
    end

endmodule : amg_ea_gen

// file: rtl/amg_mode_decode.sv
module amg_mode_decode (
    input wire amg_pkg::amg_instr_t instr,
    output amg_pkg::amg_mode_t mode,
    output logic rmw
);

    // ------------------------------------------------------------
    // Opcode column/row to addressing mode
    // ------------------------------------------------------------
    always_comb begin
        rmw = 1'b0;
        unique case (instr.opcode[7:4])
            4'h0: begin
                mode = amg_pkg::AMG_BIT_RELATIVE;
                rmw = 1'b1;
            end
            4'h1: begin
                mode = amg_pkg::AMG_BIT_DIRECT;
                rmw = 1'b1;
            end
            4'h2: mode = amg_pkg::AMG_RELATIVE;
            4'h3: begin
                mode = amg_pkg::AMG_DIRECT_SHORT;
                rmw = 1'b1;
            end
            4'h6: begin
                mode = amg_pkg::AMG_INDEXED_SHORT;
                rmw = 1'b1;
            end
            4'h7: begin
                mode = amg_pkg::AMG_INDEXED_NONE;
                rmw = 1'b1;
            end
            4'hA: mode = amg_pkg::AMG_IMMEDIATE;
            4'hB: mode = amg_pkg::AMG_DIRECT_SHORT;
            4'hC: mode = amg_pkg::AMG_DIRECT_LONG;
            4'hD: mode = amg_pkg::AMG_INDEXED_LONG;
            4'hE: mode = amg_pkg::AMG_INDEXED_SHORT;
            4'hF: mode = amg_pkg::AMG_INDEXED_NONE;
            default: mode = amg_pkg::AMG_INHERENT;
        endcase
    end

endmodule : amg_mode_decode

// file: rtl/amg_pkg.sv
package amg_pkg;

    // ------------------------------------------------------------
    // Lead codes and widths
    // ------------------------------------------------------------
    localparam logic [7:0] ALT_PTR_LEAD_CODE = 8'h90;
    localparam logic [7:0] DEREF_LEAD_CODE = 8'h92;
    localparam logic [7:0] ALT_DEREF_LEAD_CODE = 8'h91;
    localparam logic [15:0] PAGE_ZERO_TOP = 16'h00FF;
    localparam logic [15:0] RESET_ADDR = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_LEN = 2'h0;

    // ------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        AMG_INHERENT,
        AMG_IMMEDIATE,
        AMG_DIRECT_SHORT,
        AMG_DIRECT_LONG,
        AMG_INDEXED_NONE,
        AMG_INDEXED_SHORT,
        AMG_INDEXED_LONG,
        AMG_RELATIVE,
        AMG_BIT_DIRECT,
        AMG_BIT_RELATIVE
    } amg_mode_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic alt_index;
        logic deref;
    } amg_instr_t;

    typedef struct packed {
        logic [15:0] ea;
        logic [7:0] operand;
        logic is_operand;
        logic [1:0] len;
        logic short_form;
    } amg_result_t;

endpackage : amg_pkg

// file: sim/amg_ea_gen_assertions.sv
module amg_ea_gen_assertions (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_rvalid,
    input wire logic done,
    input wire logic [7:0] idx_first,
    input wire logic [7:0] idx_second,
    input wire logic rmw_out,
    input amg_pkg::amg_result_t result,
    input amg_pkg::amg_mode_t mode_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_inh_len: assert property (
        done && mode_out == amg_pkg::AMG_INHERENT |-> result.len == 2'h0 && !result.is_operand)
        else $error("inherent length wrong");
    chk_imm_operand: assert property (
        done && mode_out == amg_pkg::AMG_IMMEDIATE |-> result.len == 2'h1 && result.is_operand)
        else $error("immediate form wrong");
    chk_dir_page: assert property (
        done && mode_out == amg_pkg::AMG_DIRECT_SHORT |-> result.ea[15:8] == 8'h00)
        else $error("short direct left page zero");
    chk_noidx_ea: assert property (
        done && mode_out == amg_pkg::AMG_INDEXED_NONE
        |-> result.ea == {8'h00, idx_first} || result.ea == {8'h00, idx_second})
        else $error("no-offset indexed address wrong");
    chk_sidx_span: assert property (
        done && mode_out == amg_pkg::AMG_INDEXED_SHORT |-> result.ea <= 16'h01FE)
        else $error("short indexed beyond span");
    chk_long_wide: assert property (
        done && mode_out == amg_pkg::AMG_DIRECT_LONG |-> !result.short_form)
        else $error("long direct flagged short");
    chk_rmw_short: assert property (
        done && rmw_out |-> result.short_form)
        else $error("read-modify-write not short");
    chk_ptr_zero: assert property (
        $rose(mem_rd) |-> mem_addr[15:8] == 8'h00)
        else $error("pointer address outside page zero");
    chk_ptr_hold: assert property (
        mem_rd && !mem_rvalid |=> mem_rd && $stable(mem_addr))
        else $error("pointer read dropped early");
endmodule : amg_ea_gen_assertions

bind amg_ea_gen amg_ea_gen_assertions i_chk (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_rvalid(mem_rvalid),
    .done(done),
    .idx_first(idx_first),
    .idx_second(idx_second),
    .rmw_out(rmw_out),
    .result(result),
    .mode_out(mode_out)
);

// file: sim/amg_mem_model.sv
module amg_mem_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic slow,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata,
    output logic mem_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_cnt;

    // ----------------------------------------
    // Pointer memory, data = low address ^ C3
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= 8'h00;
            wait_cnt <= 2'h0;
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_rd && !mem_rvalid) begin
                if (slow && wait_cnt != 2'h3) begin
                    wait_cnt <= wait_cnt + 2'h1;
                end else begin
                    mem_rvalid <= 1'b1;
                    mem_rdata <= mem_addr[7:0] ^ 8'hC3;
                    wait_cnt <= 2'h0;
                end
            end
        end
    end
endmodule : amg_mem_model

// file: sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic fetch_valid = 1'b0;
    logic slow = 1'b0;
    logic [7:0] fetch_byte = 8'h00;
    logic [7:0] idx_first = 8'hF0;
    logic [7:0] idx_second = 8'h33;
    logic [15:0] pc_next = 16'h1000;
    logic [7:0] mem_rdata;
    logic mem_rvalid;
    logic [15:0] mem_addr;
    logic mem_rd, fetch_req, done, rmw_out;
    amg_pkg::amg_result_t result;
    amg_pkg::amg_mode_t mode_out;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    always #50 clk_sys = ~clk_sys;

    amg_ea_gen i_amg_ea_gen (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .start(start),
        .fetch_byte(fetch_byte), .fetch_valid(fetch_valid), .idx_first(idx_first),
        .idx_second(idx_second), .pc_next(pc_next), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .fetch_req(fetch_req), .done(done), .result(result), .mode_out(mode_out),
        .rmw_out(rmw_out));
    amg_mem_model i_amg_mem_model (.clk_sys(clk_sys), .rstn(rstn), .slow(slow),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task go(input logic [7:0] b0, b1, b2, b3, input int n);
        logic [7:0] b [4];
        b = '{b0, b1, b2, b3};
        @(posedge clk_sys);
        #10 start = 1'b1;
        @(posedge clk_sys);
        #10 start = 1'b0;
        for (int i = 0; i < n; i++) begin
            while (fetch_req !== 1'b1) begin
                @(posedge clk_sys);
                #10;
            end
            fetch_valid = 1'b1;
            fetch_byte = b[i];
            @(posedge clk_sys);
            #10;
        end
        fetch_valid = 1'b0;
        while (done !== 1'b1) begin
            @(posedge clk_sys);
            #10;
        end
    endtask : go

    task chk(input logic [15:0] ea, input logic [1:0] len, input amg_pkg::amg_mode_t md);
        cmp("ea", ea, result.ea);
        cmp("mem_addr", ea, mem_addr);
        cmp("len", {14'h0, len}, {14'h0, result.len});
        cmp("mode", 16'(md), 16'(mode_out));
    endtask : chk

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_simple;
        go(8'h81, 8'h00, 8'h00, 8'h00, 1);
        cmp("inh len", 16'h0, {14'h0, result.len});
        go(8'hA6, 8'h55, 8'h00, 8'h00, 2);
        cmp("operand", 16'h0055, {8'h00, result.operand});
        cmp("is_operand", 16'h1, {15'h0, result.is_operand});
    endtask : t_simple

    task t_direct;
        go(8'hB6, 8'h10, 8'h00, 8'h00, 2);
        chk(16'h0010, 2'h1, amg_pkg::AMG_DIRECT_SHORT);
        cmp("short", 16'h1, {15'h0, result.short_form});
        go(8'hC6, 8'h12, 8'h34, 8'h00, 3);
        chk(16'h1234, 2'h2, amg_pkg::AMG_DIRECT_LONG);
    endtask : t_direct

    task t_indexed;
        go(8'hF6, 8'h00, 8'h00, 8'h00, 1);
        chk(16'h00F0, 2'h0, amg_pkg::AMG_INDEXED_NONE);
        go(8'h90, 8'hF6, 8'h00, 8'h00, 2);
        cmp("alt ea", 16'h0033, result.ea);
        cmp("alt len", 16'h0, {14'h0, result.len});
        go(8'hE6, 8'hFF, 8'h00, 8'h00, 2);
        chk(16'h01EF, 2'h1, amg_pkg::AMG_INDEXED_SHORT);
        go(8'hD6, 8'h12, 8'h00, 8'h00, 3);
        chk(16'h12F0, 2'h2, amg_pkg::AMG_INDEXED_LONG);
    endtask : t_indexed

    task t_indirect;
        slow = 1'b1;
        go(8'h92, 8'hB6, 8'h10, 8'h00, 3);
        cmp("ind ea", 16'h00D3, result.ea);
        cmp("ind len", 16'h1, {14'h0, result.len});
        go(8'h92, 8'hC6, 8'h10, 8'h00, 3);
        cmp("ind long ea", 16'hD3D2, result.ea);
        cmp("ind long len", 16'h1, {14'h0, result.len});
        slow = 1'b0;
        go(8'h92, 8'hE6, 8'h10, 8'h00, 3);
        cmp("ind idx ea", 16'h01C3, result.ea);
        go(8'h91, 8'hE6, 8'h10, 8'h00, 3);
        cmp("ind alt ea", 16'h0106, result.ea);
    endtask : t_indirect

    task t_relative;
        go(8'h20, 8'h80, 8'h00, 8'h00, 2);
        chk(16'h0F80, 2'h1, amg_pkg::AMG_RELATIVE);
        go(8'h20, 8'h7F, 8'h00, 8'h00, 2);
        chk(16'h107F, 2'h1, amg_pkg::AMG_RELATIVE);
        go(8'h92, 8'h20, 8'h10, 8'h00, 3);
        chk(16'h0FD3, 2'h1, amg_pkg::AMG_RELATIVE);
    endtask : t_relative

    task t_rmw;
        go(8'h3A, 8'h10, 8'h00, 8'h00, 2);
        cmp("rmw", 16'h1, {15'h0, rmw_out});
        cmp("rmw short", 16'h1, {15'h0, result.short_form});
        cmp("rmw ea", 16'h0010, result.ea);
    endtask : t_rmw

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        #10 rstn = 1'b1;
        t_simple;
        t_direct;
        t_indexed;
        t_indirect;
        t_relative;
        t_rmw;
        tally_and_finish;
    end
endmodule : testbench
